/* File: tcp_pkg.sv */
// Package with register map, field positions and reset values of the PWM timer.
package tcp_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam int         ADDR_W                    = 4;
  localparam int         DATA_W                    = 8;
  localparam logic [3:0] ADDR_CLOCK_SELECT         = 4'h0;
  localparam logic [3:0] ADDR_POLARITY_CLOCK_SRC   = 4'h1;
  localparam logic [3:0] ADDR_SCALED_CLOCK_DIVISOR = 4'h2;
  localparam logic [3:0] ADDR_CHANNEL_ENABLE       = 4'h3;
  localparam logic [3:0] ADDR_COUNTER_BASE         = 4'h4;
  localparam logic [3:0] ADDR_PERIOD_BASE          = 4'h8;
  localparam logic [3:0] ADDR_DUTY_BASE            = 4'hc;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int JOIN_UPPER_PAIR_BIT  = 7;
  localparam int JOIN_LOWER_PAIR_BIT  = 6;
  localparam int CLOCK_A_PRESCALE_LSB = 4;
  localparam int CLOCK_B_PRESCALE_LSB = 0;
  localparam int CLOCK_SELECT_LSB     = 4;
  localparam int POLARITY_LSB         = 0;
  localparam int SCALED_CLOCK_TEST_BIT = 7;
  localparam int PERIOD_RESET_DIS_BIT = 5;
  localparam int ENABLE_LSB           = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam logic [6:0] PRESCALE_ONES  = 7'h7f;

endpackage

/* File: tcp_pwm_timer.sv */
// Four-channel 8-bit PWM timer with pair joining, prescalers and register port.
// Operation
// - Four channels: counter, period, duty registers.
// - Channel runs and drives only when enabled.
// - Period match: polarity level, counter cleared.
// - Duty match inverts output for rest.
// - Polarity 0 starts low, 1 starts high.
// - Period and duty load on counter clear.
// - Counter write clears it; always readable.
// - Clock A is E over 1,2,4,8.
// - Clock B is E over two-power field.
// - Clock S is A over scaler, then two.
// - Clock select picks A/B or S.
// - Join bit makes one 16-bit channel.
// - Pair uses low channel clock; frees pin.
// - High counter read latches low byte.
// - Low write clears pair; high write ignored.
// - Test bits: S readback, no period clear.
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

module tcp_pwm_timer (
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [tcp_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [tcp_pkg::DATA_W-1:0]   wr_data_in,
  input  wire logic                         wr_en_in,
  input  wire logic                         rd_en_in,
  input  wire logic                         test_mode_in,
  output logic      [tcp_pkg::DATA_W-1:0]   rd_data_out,
  output logic      [3:0]                   pwm_out,
  output logic      [3:0]                   pwm_oe_out
);
  import tcp_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // A tick of E divided by two to the power n, from the free prescaler.
  function automatic logic pow2_tick(input logic [6:0] pre, input logic [2:0] n);
    logic [6:0] m;
    m = PRESCALE_ONES >> (3'd7 - n);
    return &(pre | ~m);
  endfunction

  // ---------------------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------------------
  logic [7:0] clock_select_reg;
  logic [7:0] polarity_clock_source_reg;
  logic [7:0] scaled_clock_divisor;
  logic [3:0] channel_enable_bits;
  logic       scaled_clock_test;
  logic       period_match_reset_disable;
  logic [7:0] channel_counter [4];
  logic [7:0] channel_period  [4];
  logic [7:0] channel_duty    [4];
  logic [7:0] active_period   [4];
  logic [7:0] active_duty     [4];
  logic [3:0] out_level;
  logic [6:0] prescale;
  logic [7:0] scale_count;
  logic       s_half;
  logic [1:0] test_sync;
  logic [1:0] latch_valid;
  logic [7:0] latch_byte [2];

  logic       join_lower_pair;
  logic       join_upper_pair;
  logic [1:0] pair_joined;
  logic [3:0] channel_clock_select;
  logic [3:0] channel_polarity;
  logic       tick_a;
  logic       tick_b;
  logic       scale_hit;
  logic       tick_s;
  logic [3:0] ch_tick;
  logic       test_mode;
  logic       wr_counter;
  logic       rd_counter;
  logic [1:0] ch_sel;

  assign join_lower_pair      = clock_select_reg[JOIN_LOWER_PAIR_BIT];
  assign join_upper_pair      = clock_select_reg[JOIN_UPPER_PAIR_BIT];
  assign pair_joined          = {join_upper_pair, join_lower_pair};
  assign channel_clock_select = polarity_clock_source_reg[CLOCK_SELECT_LSB +: 4];
  assign channel_polarity     = polarity_clock_source_reg[POLARITY_LSB +: 4];
  assign test_mode            = test_sync[1];
  assign wr_counter           = wr_en_in && (addr_in[3:2] == ADDR_COUNTER_BASE[3:2]);
  assign rd_counter           = rd_en_in && (addr_in[3:2] == ADDR_COUNTER_BASE[3:2]);
  assign ch_sel               = addr_in[1:0];

  // ---------------------------------------------------------------------------
  // Test mode strap synchroniser
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      test_sync <= 2'b00;
    end else begin
      test_sync <= {test_sync[0], test_mode_in};
    end
  end

  // ---------------------------------------------------------------------------
  // Clock generation
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prescale <= PRESCALE_RESET;
    end else begin
      prescale <= prescale + 7'h01;
    end
  end

  assign tick_a = pow2_tick(prescale,
                            {1'b0, clock_select_reg[CLOCK_A_PRESCALE_LSB +: 2]});
  assign tick_b = pow2_tick(prescale, clock_select_reg[CLOCK_B_PRESCALE_LSB +: 3]);

  // A divisor of zero wraps the compare to 8'hff, which gives 256 A ticks.
  assign scale_hit = tick_a && (scale_count == (scaled_clock_divisor - 8'h01));
  assign tick_s    = scale_hit && s_half;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scale_count <= RESET_BYTE;
      s_half      <= 1'b0;
    end else if (scale_hit) begin
      scale_count <= RESET_BYTE;
      s_half      <= ~s_half;
    end else if (tick_a) begin
      scale_count <= scale_count + 8'h01;
    end
  end

  // Channels 0-1 choose A or S, channels 2-3 choose B or S.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (channel_clock_select[i]) begin
        ch_tick[i] = tick_s;
      end else begin
        ch_tick[i] = (i < 2) ? tick_a : tick_b;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clock_select_reg           <= RESET_BYTE;
      polarity_clock_source_reg  <= RESET_BYTE;
      scaled_clock_divisor       <= RESET_BYTE;
      channel_enable_bits        <= 4'h0;
    end else if (wr_en_in) begin
      case (addr_in)
        ADDR_CLOCK_SELECT: begin
          clock_select_reg <= wr_data_in;
        end
        ADDR_POLARITY_CLOCK_SRC: begin
          polarity_clock_source_reg <= wr_data_in;
        end
        ADDR_SCALED_CLOCK_DIVISOR: begin
          scaled_clock_divisor <= wr_data_in;
        end
        ADDR_CHANNEL_ENABLE: begin
          channel_enable_bits <= wr_data_in[ENABLE_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  // Factory bits only move in special test mode and clear as soon as it ends,
  // even while software keeps writing, so normal code can never see them set.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scaled_clock_test          <= 1'b0;
      period_match_reset_disable <= 1'b0;
    end else if (!test_mode) begin
      scaled_clock_test          <= 1'b0;
      period_match_reset_disable <= 1'b0;
    end else if (wr_en_in && (addr_in == ADDR_CHANNEL_ENABLE)) begin
      scaled_clock_test          <= wr_data_in[SCALED_CLOCK_TEST_BIT];
      period_match_reset_disable <= wr_data_in[PERIOD_RESET_DIS_BIT];
    end
  end

  // Buffered period and duty values, written by software at any time.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        channel_period[i] <= RESET_BYTE;
        channel_duty[i]   <= RESET_BYTE;
      end
    end else if (wr_en_in) begin
      if (addr_in[3:2] == ADDR_PERIOD_BASE[3:2]) begin
        channel_period[ch_sel] <= wr_data_in;
      end
      if (addr_in[3:2] == ADDR_DUTY_BASE[3:2]) begin
        channel_duty[ch_sel] <= wr_data_in;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Channel engines
  // ---------------------------------------------------------------------------
  // Pair p holds high channel 2p and low channel 2p+1.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        channel_counter[i] <= RESET_BYTE;
        active_period[i]   <= RESET_BYTE;
        active_duty[i]     <= RESET_BYTE;
      end
      out_level <= 4'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        int hi;
        int lo;
        logic [15:0] cnt16;
        hi = 2 * p;
        lo = 2 * p + 1;
        cnt16 = {channel_counter[hi], channel_counter[lo]};
        if (pair_joined[p]) begin
          if (wr_counter && (ch_sel == 2'(lo))) begin
            channel_counter[hi] <= RESET_BYTE;
            channel_counter[lo] <= RESET_BYTE;
            for (int k = hi; k <= lo; k++) begin
              active_period[k] <= channel_period[k];
              active_duty[k]   <= channel_duty[k];
            end
          end else if (channel_enable_bits[lo] && ch_tick[lo]) begin
            if (cnt16 == {active_period[hi], active_period[lo]}) begin
              out_level[lo] <= channel_polarity[lo];
              if (!period_match_reset_disable) begin
                channel_counter[hi] <= RESET_BYTE;
                channel_counter[lo] <= RESET_BYTE;
                for (int k = hi; k <= lo; k++) begin
                  active_period[k] <= channel_period[k];
                  active_duty[k]   <= channel_duty[k];
                end
              end else begin
                {channel_counter[hi], channel_counter[lo]} <= cnt16 + 16'h0001;
              end
            end else begin
              if (cnt16 == {active_duty[hi], active_duty[lo]}) begin
                out_level[lo] <= ~channel_polarity[lo];
              end
              {channel_counter[hi], channel_counter[lo]} <= cnt16 + 16'h0001;
            end
          end
        end else begin
          for (int k = hi; k <= lo; k++) begin
            if (wr_counter && (ch_sel == 2'(k))) begin
              channel_counter[k] <= RESET_BYTE;
              active_period[k]   <= channel_period[k];
              active_duty[k]     <= channel_duty[k];
            end else if (channel_enable_bits[k] && ch_tick[k]) begin
              if (channel_counter[k] == active_period[k]) begin
                out_level[k] <= channel_polarity[k];
                if (!period_match_reset_disable) begin
                  channel_counter[k] <= RESET_BYTE;
                  active_period[k]   <= channel_period[k];
                  active_duty[k]     <= channel_duty[k];
                end else begin
                  channel_counter[k] <= channel_counter[k] + 8'h01;
                end
              end else begin
                if (channel_counter[k] == active_duty[k]) begin
                  out_level[k] <= ~channel_polarity[k];
                end
                channel_counter[k] <= channel_counter[k] + 8'h01;
              end
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------------
  // A joined pair drives only the low channel pin; the high pin is left to GPIO.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pwm_out    <= 4'h0;
      pwm_oe_out <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if ((i % 2 == 0) && pair_joined[i / 2]) begin
          pwm_out[i]    <= 1'b0;
          pwm_oe_out[i] <= 1'b0;
        end else begin
          pwm_out[i]    <= channel_enable_bits[i] & out_level[i];
          pwm_oe_out[i] <= channel_enable_bits[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Coherent read latch
  // ---------------------------------------------------------------------------
  // The latch holds for exactly one cycle, so the low byte must be read next.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      latch_valid   <= 2'b00;
      latch_byte[0] <= RESET_BYTE;
      latch_byte[1] <= RESET_BYTE;
    end else begin
      for (int p = 0; p < 2; p++) begin
        latch_valid[p] <= rd_counter && pair_joined[p] && (ch_sel == 2'(2 * p));
        latch_byte[p]  <= channel_counter[2 * p + 1];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_data_out <= RESET_BYTE;
    end else if (rd_en_in) begin
      case (addr_in[3:2])
        ADDR_COUNTER_BASE[3:2]: begin
          if (ch_sel[0] && pair_joined[ch_sel[1]] && latch_valid[ch_sel[1]]) begin
            rd_data_out <= latch_byte[ch_sel[1]];
          end else begin
            rd_data_out <= channel_counter[ch_sel];
          end
        end
        ADDR_PERIOD_BASE[3:2]: begin
          rd_data_out <= channel_period[ch_sel];
        end
        ADDR_DUTY_BASE[3:2]: begin
          rd_data_out <= channel_duty[ch_sel];
        end
        default: begin
          case (addr_in)
            ADDR_CLOCK_SELECT: begin
              // Bit 3 is reserved and reads as zero.
              rd_data_out <= {clock_select_reg[7:4], 1'b0, clock_select_reg[2:0]};
            end
            ADDR_POLARITY_CLOCK_SRC: begin
              rd_data_out <= polarity_clock_source_reg;
            end
            ADDR_SCALED_CLOCK_DIVISOR: begin
              if (scaled_clock_test) begin
                rd_data_out <= {7'h00, s_half};
              end else begin
                rd_data_out <= scaled_clock_divisor;
              end
            end
            default: begin
              rd_data_out <= {scaled_clock_test, 1'b0, period_match_reset_disable,
                              1'b0, channel_enable_bits};
            end
          endcase
        end
      endcase
    end else begin
      rd_data_out <= RESET_BYTE;
    end
  end

endmodule

/* File: tcp_pin_load.sv */
// Model of the external loads on the four PWM port pins.
`timescale 1ns/1ps

module tcp_pin_load (
  input  wire logic [3:0] pwm_in,
  input  wire logic [3:0] oe_in,
  output logic      [3:0] pin_out
);
  // A released pin is pulled low by the board, so a stale level never shows.
  always_comb begin
    pin_out = pwm_in & oe_in;
  end
endmodule

/* File: tcp_pwm_timer_monitor.sv */
// Port-level assertions for the PWM timer.
`timescale 1ns/1ps

module tcp_pwm_timer_monitor (
  input wire logic                       clk_in,
  input wire logic                       arst_n_in,
  input wire logic [tcp_pkg::ADDR_W-1:0] addr_in,
  input wire logic [tcp_pkg::DATA_W-1:0] wr_data_in,
  input wire logic                       wr_en_in,
  input wire logic                       rd_en_in,
  input wire logic                       test_mode_in,
  input wire logic [tcp_pkg::DATA_W-1:0] rd_data_out,
  input wire logic [3:0]                 pwm_out,
  input wire logic [3:0]                 pwm_oe_out
);
  import tcp_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic join_lo_q;

  // Shadow of the lower pair join bit, since the checker cannot see registers.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      join_lo_q <= 1'b0;
    end else if (wr_en_in && addr_in == ADDR_CLOCK_SELECT) begin
      join_lo_q <= wr_data_in[JOIN_LOWER_PAIR_BIT];
    end
  end

  property p_rst_out;
    disable iff (1'b0) !arst_n_in |-> pwm_oe_out == 4'h0 && rd_data_out == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not zero in reset");
  property p_rd_idle;
    !rd_en_in |=> rd_data_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
  property p_pin_off;
    (pwm_out & ~pwm_oe_out) == 4'h0;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("undriven pin high");
  property p_dis0;
    wr_en_in && addr_in == ADDR_CHANNEL_ENABLE && !wr_data_in[0] |-> ##[1:3] !pwm_oe_out[0];
  endproperty
  a_dis0: assert property (p_dis0) else $error("pin 0 driven while disabled");
  property p_en1;
    wr_en_in && addr_in == ADDR_CHANNEL_ENABLE && wr_data_in[1] |-> ##[1:3] pwm_oe_out[1];
  endproperty
  a_en1: assert property (p_en1) else $error("pin 1 not driven when enabled");
  property p_join_rel;
    join_lo_q && $past(join_lo_q, 3) |-> !pwm_oe_out[0];
  endproperty
  a_join_rel: assert property (p_join_rel) else $error("joined high pin driven");
  property p_per_rb;
    wr_en_in && addr_in == ADDR_PERIOD_BASE ##1 rd_en_in && addr_in == ADDR_PERIOD_BASE
      |=> rd_data_out == $past(wr_data_in, 2);
  endproperty
  a_per_rb: assert property (p_per_rb) else $error("period readback wrong");
  property p_cnt_clr;
    wr_en_in && addr_in == ADDR_COUNTER_BASE + 4'h1 ##1
      rd_en_in && addr_in == ADDR_COUNTER_BASE + 4'h1 |=> rd_data_out <= 8'h01;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
  property p_test_bits;
    rd_en_in && addr_in == ADDR_CHANNEL_ENABLE && !test_mode_in && !$past(test_mode_in, 1)
      && !$past(test_mode_in, 2) && !$past(test_mode_in, 3) |=> (rd_data_out & 8'hf0) == 8'h00;
  endproperty
  a_test_bits: assert property (p_test_bits) else $error("test bits set");
endmodule

bind tcp_pwm_timer tcp_pwm_timer_monitor u_mon (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .test_mode_in(test_mode_in),
  .rd_data_out(rd_data_out), .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out)
);

/* File: tcp_testbench.sv */
// Self-checking testbench for the PWM timer.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench;
  import tcp_pkg::*;
  logic       clk_in, arst_n_in, wr_en_in, rd_en_in, test_mode_in;
  logic [3:0] addr_in, pwm_out, pwm_oe_out, pin;
  logic [7:0] wr_data_in, rd_data_out, v, w;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         hi, dd;

  tcp_pwm_timer u_tcp_pwm_timer (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .test_mode_in(test_mode_in), .rd_data_out(rd_data_out), .pwm_out(pwm_out),
    .pwm_oe_out(pwm_oe_out));
  tcp_pin_load u_tcp_pin_load (.pwm_in(pwm_out), .oe_in(pwm_oe_out), .pin_out(pin));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One access per call; strobes stay up so calls may run back to back.
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
    wr_en_in <= wr;
    rd_en_in <= !wr;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    #1 v = rd_data_out;
  endtask

  task automatic idle(input int n);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b0;
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Counts high cycles on one pin; windows are whole periods, so phase is irrelevant.
  task automatic meas(input int ch, input int n);
    idle(0);
    hi = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1 hi += int'(pin[ch]);
    end
  endtask

  initial begin
    repeat (50000) @(posedge clk_in);
    n_mismatch++;
    complete_run();
  end

  initial begin
    arst_n_in = 1'b0;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    test_mode_in = 1'b0;
    addr_in = 4'h0;
    wr_data_in = 8'h00;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    #1;
    for (int a = 0; a < 16; a++) begin
      acc(0, 4'(a), 8'h00);
      `CHK(v, 8'h00)
    end
    for (int a = 8; a < 16; a++) begin
      acc(1, 4'(a), 8'(8'h30 + a));
      acc(0, 4'(a), 8'h00);
      `CHK(v, 8'(8'h30 + a))
    end
    acc(1, ADDR_CLOCK_SELECT, 8'hff);
    acc(0, ADDR_CLOCK_SELECT, 8'h00);
    `CHK(v, 8'hf7)
    acc(1, ADDR_CLOCK_SELECT, 8'h00);
    acc(1, ADDR_PERIOD_BASE, 8'h03);
    acc(1, ADDR_DUTY_BASE, 8'h00);
    acc(1, ADDR_CHANNEL_ENABLE, 8'h01);
    for (int pol = 0; pol < 2; pol++) begin
      for (int ps = 0; ps < 4; ps++) begin
        acc(1, ADDR_CLOCK_SELECT, 8'(ps << 4));
        acc(1, ADDR_POLARITY_CLOCK_SRC, 8'(pol));
        acc(1, ADDR_COUNTER_BASE, 8'h5a);
        idle(8 << ps);
        meas(0, 8 << ps);
        `CHK(hi, (pol == 1 ? 2 : 6) << ps)
      end
    end
    acc(1, ADDR_CLOCK_SELECT, 8'h00);
    acc(1, ADDR_PERIOD_BASE, 8'hff);
    acc(1, ADDR_COUNTER_BASE, 8'h00);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    w = v;
    idle(9);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(8'(v - w), 8'h0a)
    acc(1, ADDR_PERIOD_BASE, 8'h03);
    idle(9);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(v > 8'h05, 1'b1)
    acc(1, ADDR_COUNTER_BASE, 8'hff);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(v < 8'h02, 1'b1)
    acc(1, ADDR_CHANNEL_ENABLE, 8'h00);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    w = v;
    idle(9);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(v, w)
    `CHK(pwm_oe_out, 4'h0)
    acc(1, ADDR_POLARITY_CLOCK_SRC, 8'h00);
    acc(1, ADDR_PERIOD_BASE + 4'h2, 8'h03);
    acc(1, ADDR_DUTY_BASE + 4'h2, 8'h00);
    acc(1, ADDR_CHANNEL_ENABLE, 8'h04);
    for (int b = 0; b < 8; b++) begin
      acc(1, ADDR_CLOCK_SELECT, 8'(b));
      acc(1, ADDR_COUNTER_BASE + 4'h2, 8'h00);
      idle(8 << b);
      meas(2, 8 << b);
      `CHK(hi, 6 << b)
    end
    acc(1, ADDR_CLOCK_SELECT, 8'h00);
    acc(1, ADDR_POLARITY_CLOCK_SRC, 8'h80);
    acc(1, ADDR_PERIOD_BASE + 4'h3, 8'h03);
    acc(1, ADDR_DUTY_BASE + 4'h3, 8'h00);
    acc(1, ADDR_CHANNEL_ENABLE, 8'h08);
    for (int d = 0; d < 3; d++) begin
      dd = (d == 0) ? 1 : (d == 1) ? 3 : 256;
      acc(1, ADDR_SCALED_CLOCK_DIVISOR, 8'(dd));
      acc(1, ADDR_COUNTER_BASE + 4'h3, 8'h00);
      idle(8 * dd + 520);
      meas(3, 8 * dd);
      `CHK(hi, 6 * dd)
    end
    acc(1, ADDR_CLOCK_SELECT, 8'h40);
    acc(1, ADDR_POLARITY_CLOCK_SRC, 8'h11);
    acc(1, ADDR_PERIOD_BASE, 8'h01);
    acc(1, ADDR_PERIOD_BASE + 4'h1, 8'h03);
    acc(1, ADDR_DUTY_BASE, 8'h00);
    acc(1, ADDR_DUTY_BASE + 4'h1, 8'h80);
    acc(1, ADDR_CHANNEL_ENABLE, 8'h02);
    acc(1, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    idle(260);
    meas(1, 260);
    `CHK(hi, 131)
    `CHK(pwm_oe_out, 4'h2)
    acc(1, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    idle(3);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(v, 8'h00)
    acc(0, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    w = v;
    acc(0, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    `CHK(8'(v - w), 8'h02)
    idle(20);
    acc(1, ADDR_COUNTER_BASE, 8'h00);
    acc(0, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    `CHK(v > 8'h10, 1'b1)
    acc(1, ADDR_COUNTER_BASE + 4'h1, 8'h77);
    acc(0, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    `CHK(v < 8'h02, 1'b1)
    acc(1, ADDR_CHANNEL_ENABLE, 8'ha2);
    acc(0, ADDR_CHANNEL_ENABLE, 8'h00);
    `CHK(v, 8'h02)
    test_mode_in <= 1'b1;
    idle(4);
    acc(1, ADDR_CHANNEL_ENABLE, 8'h22);
    acc(0, ADDR_CHANNEL_ENABLE, 8'h00);
    `CHK(v, 8'h22)
    acc(1, ADDR_COUNTER_BASE + 4'h1, 8'h00);
    idle(300);
    acc(0, ADDR_COUNTER_BASE, 8'h00);
    `CHK(v, 8'h01)
    acc(1, ADDR_CHANNEL_ENABLE, 8'h82);
    acc(0, ADDR_SCALED_CLOCK_DIVISOR, 8'h00);
    `CHK(v & 8'hfe, 8'h00)
    test_mode_in <= 1'b0;
    idle(6);
    acc(0, ADDR_CHANNEL_ENABLE, 8'h00);
    `CHK(v, 8'h02)
    idle(1);
    complete_run();
  end
endmodule
